/* File: bench/host_mode_driver.sv */
// Host model driving the two mode select pins
`timescale 1ns/1ps
`default_nettype none
module host_mode_driver (
    // Clock
    input wire logic sys_clk,
    // Levels the host wants
    input wire logic want_power,
    input wire logic want_radio,
    // Mode pins
    output logic power_mode_select,
    output logic radio_mode_select
);
    // Pins move just after the edge, as a port register would
    always_ff @(posedge sys_clk) begin
        power_mode_select <= want_power;
        radio_mode_select <= want_radio;
    end
endmodule // host_mode_driver
`default_nettype wire

/* File: bench/transceiver_mode_state_control_tb.sv */
// Testbench for the transceiver state controller
`timescale 1ns/1ps
`default_nettype none
module transceiver_mode_state_control_tb;
    import trx_state_pkg::*;
    logic sys_clk = 1'h0, srst = 1'h1, want_p = 1'h0, want_r = 1'h0, wr = 1'h0;
    logic rxd = 1'h1, cd = 1'h1, syn = 1'h1, fev = 1'h1, pms, rms;
    logic sdi = 1'h1, edi = 1'h1, cal = 1'h0, tmp = 1'h0;
    logic [MODE_CTRL_W-1:0] ctrl = MODE_CTRL_RST;
    logic txd, txe, sdo, sdoe, edo, edoe, fst, cko, rck, rsp, osc, ana, txp, rxp;
    logic [2:0] st;
    int fail_count = 0;
    int total_checks = 0;
    host_mode_driver host (.sys_clk(sys_clk), .want_power(want_p), .want_radio(want_r),
        .power_mode_select(pms), .radio_mode_select(rms));
    transceiver_mode_state_control dut (.sys_clk(sys_clk), .srst(srst),
        .power_mode_select(pms), .radio_mode_select(rms), .mode_ctrl(ctrl),
        .mode_ctrl_wr(wr), .cal_busy(cal), .temp_busy(tmp), .rx_data(rxd),
        .carrier_detect(cd), .rx_sync(syn), .fifo_event(fev), .tx_data(txd),
        .tx_mod_enable(txe), .shared_data_pin_in(sdi), .shared_data_pin_out(sdo),
        .shared_data_pin_oe(sdoe), .enable_detect_pin_in(edi), .enable_detect_pin_out(edo),
        .enable_detect_pin_oe(edoe), .fifo_status_pin(fst), .clock_output_pin(cko),
        .rx_clock_pin(rck), .receive_sync_pulse(rsp), .osc_enable(osc),
        .analog_enable(ana), .tx_power(txp), .rx_power(rxp), .state_out(st));
    initial forever #5 sys_clk = ~sys_clk;
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    // Pin edge reaches the state two edges after the request
    task automatic go(input logic p, input logic r);
        @(posedge sys_clk);
        want_p <= p;
        want_r <= r;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    // A divide-by-8 clock rises exactly twice in any 16 cycles
    task automatic rises(ref logic s);
        int n;
        logic last;
        n = 0;
        last = s;
        repeat (16) begin
            @(posedge sys_clk);
            #1;
            n += int'(s & !last);
            last = s;
        end
        check(12'(n), 12'h002);
    endtask
    task automatic t_standby;
        go(1'h1, 1'h0);
        check(12'({st, osc, ana}), 12'h006);
        rises(cko);
        check(12'(fst), 12'h001);
        $display("standby done");
    endtask
    task automatic t_radio;
        go(1'h1, 1'h1);
        // Pin data follows the state by one cycle
        @(posedge sys_clk);
        #1;
        check(12'({st, rxp, txp, sdoe, sdo, edoe, edo}), 12'h0af);
        rises(rck);
        check(12'({rsp, ana}), 12'h003);
        @(posedge sys_clk);
        ctrl[DIR_BIT_POS] <= DIR_TX;
        wr <= 1'h1;
        @(posedge sys_clk);
        wr <= 1'h0;
        repeat (2) @(posedge sys_clk);
        #1;
        check(12'({txp, rxp, sdoe, edoe, txd, txe}), 12'h023);
        @(posedge sys_clk);
        sdi <= 1'h0;
        edi <= 1'h0;
        @(posedge sys_clk);
        #1;
        check(12'({txd, txe, sdoe}), 12'h000);
        go(1'h1, 1'h0);
        check(12'(st), 12'h001);
        $display("radio done");
    endtask
    task automatic t_sleep;
        go(1'h1, 1'h1);
        check(12'({st, txp}), 12'h005);
        go(1'h0, 1'h1);
        check(12'({st, osc, ana}), 12'h000);
        @(posedge sys_clk);
        #1;
        check(12'({cko, fst}), 12'h000);
        $display("sleep done");
    endtask
    // Calibration and temperature requests from standby
    task automatic t_substates;
        @(posedge sys_clk);
        cal <= 1'h1;
        repeat (2) @(posedge sys_clk);
        #1;
        check(12'({st, osc, ana}), 12'h00f);
        @(posedge sys_clk);
        cal <= 1'h0;
        tmp <= 1'h1;
        repeat (2) @(posedge sys_clk);
        #1;
        check(12'({st, osc, ana}), 12'h013);
        @(posedge sys_clk);
        tmp <= 1'h0;
        repeat (2) @(posedge sys_clk);
        #1;
        check(12'({st, osc, ana}), 12'h006);
        $display("substates done");
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #5000;
        fail_count++;
        close_out();
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        srst <= 1'h0;
        #1;
        check(12'({st, osc, ana, cko, sdoe}), 12'h000);
        $display("reset done");
        t_standby();
        t_radio();
        t_substates();
        t_sleep();
        close_out();
    end
endmodule // transceiver_mode_state_control_tb
`default_nettype wire

/* File: bench/trx_state_monitor.sv */
// Port checker for the transceiver state controller
`timescale 1ns/1ps
`default_nettype none
module trx_state_monitor (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic power_mode_select,
    input wire logic radio_mode_select,
    input wire logic shared_data_pin_oe,
    input wire logic osc_enable,
    input wire logic analog_enable,
    input wire logic tx_power,
    input wire logic rx_power,
    input wire logic clock_output_pin,
    input wire logic [2:0] state_out
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    chk_low_sleep: assert property (!power_mode_select |=> state_out == 3'h0)
        else $error("no sleep after power select low");
    chk_rise_standby: assert property ($rose(power_mode_select) && state_out == 3'h0
        |=> state_out == 3'h1) else $error("no standby after rise");
    chk_sleep_dark: assert property (state_out == 3'h0 |-> !osc_enable && !analog_enable)
        else $error("power on in sleep");
    chk_standby_osc: assert property (state_out == 3'h1 |-> osc_enable && !analog_enable)
        else $error("standby power wrong");
    chk_clock_idle: assert property (state_out == 3'h0 ##1 state_out == 3'h0
        |-> !clock_output_pin) else $error("clock out in sleep");
    chk_radio_pins: assert property (state_out == 3'h2
        |-> $past(power_mode_select) && $past(radio_mode_select)) else $error("radio w/o pins");
    chk_rx_drives: assert property (rx_power |-> shared_data_pin_oe && !tx_power)
        else $error("receive pin not driven");
    chk_tx_releases: assert property (tx_power |-> !shared_data_pin_oe && state_out == 3'h2)
        else $error("transmit pin driven");
    chk_one_state: assert property (state_out <= 3'h4)
        else $error("state code out of range");
endmodule // trx_state_monitor
bind transceiver_mode_state_control trx_state_monitor mon (.sys_clk(sys_clk), .srst(srst),
    .power_mode_select(power_mode_select), .radio_mode_select(radio_mode_select),
    .shared_data_pin_oe(shared_data_pin_oe), .osc_enable(osc_enable),
    .analog_enable(analog_enable), .tx_power(tx_power), .rx_power(rx_power),
    .clock_output_pin(clock_output_pin), .state_out(state_out));
`default_nettype wire

/* File: core/transceiver_mode_state_control.sv */
// Top-level operating-state control of the transceiver digital core
`timescale 1ns/1ps
`default_nettype none
module transceiver_mode_state_control
    import trx_state_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Mode pins
    input wire logic power_mode_select,
    input wire logic radio_mode_select,
    // Mode control word from the serial control block
    input wire logic [MODE_CTRL_W-1:0] mode_ctrl,
    input wire logic mode_ctrl_wr,
    // Sub-state requests from calibration and temperature blocks
    input wire logic cal_busy,
    input wire logic temp_busy,
    // Datapath side
    input wire logic rx_data,
    input wire logic carrier_detect,
    input wire logic rx_sync,
    input wire logic fifo_event,
    output logic tx_data,
    output logic tx_mod_enable,
    // Shared data pin
    input wire logic shared_data_pin_in,
    output logic shared_data_pin_out,
    output logic shared_data_pin_oe,
    // Enable/detect pin
    input wire logic enable_detect_pin_in,
    output logic enable_detect_pin_out,
    output logic enable_detect_pin_oe,
    // Status and clock outputs
    output logic fifo_status_pin,
    output logic clock_output_pin,
    output logic rx_clock_pin,
    output logic receive_sync_pulse,
    // Power controls and state output
    output logic osc_enable,
    output logic analog_enable,
    output logic tx_power,
    output logic rx_power,
    output logic [2:0] state_out
);

    // State and pin history
    top_state_e state_reg;
    top_state_e state_next;
    logic pms_prev_reg;
    // Direction latch
    logic dir_reg;
    logic dir_next;
    // Clock output divider
    logic [3:0] clk_cnt_reg;
    logic [3:0] clk_cnt_next;
    logic clk_out_reg;
    logic clk_out_next;
    // Receive sampling clock divider
    logic [3:0] rx_cnt_reg;
    logic [3:0] rx_cnt_next;
    logic rx_clk_reg;
    logic rx_clk_next;
    // Registered pin data
    logic sync_reg;
    logic sync_next;
    logic sdo_reg;
    logic sdo_next;
    logic cd_reg;
    logic cd_next;
    logic fifo_reg;
    logic fifo_next;
    logic txd_reg;
    logic txd_next;
    logic txen_reg;
    logic txen_next;

    // Divider helpers shared by both clock outputs
    function automatic logic div_wrap(input logic [3:0] cnt, input logic [3:0] half);
        div_wrap = (cnt == half - 4'h1);
    endfunction

    function automatic logic [3:0] div_count(input logic [3:0] cnt, input logic wrap);
        if (wrap) begin
            div_count = 4'h0;
        end else begin
            div_count = cnt + 4'h1;
        end
    endfunction

    // State decode used across the pin logic
    function automatic logic is_state(input top_state_e cur, input top_state_e want);
        is_state = (cur == want);
    endfunction

    wire pms_rise = power_mode_select && !pms_prev_reg;
    wire in_sleep = is_state(state_reg, ST_SLEEP);
    wire in_radio = is_state(state_reg, ST_RADIO);
    wire in_cal = is_state(state_reg, ST_CAL);
    wire in_temp = is_state(state_reg, ST_TEMP);
    wire receiving = in_radio && (dir_reg == DIR_RX);
    wire transmitting = in_radio && (dir_reg == DIR_TX);
    wire radio_req = ({radio_mode_select, power_mode_select} == MODE_RADIO);
    wire osc_on = !in_sleep;
    wire clk_wrap = div_wrap(clk_cnt_reg, CLK_OUT_HALF);
    wire rx_wrap = div_wrap(rx_cnt_reg, RX_CLK_HALF);

    // Next state; power mode select low dominates everything
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_SLEEP: begin
                if (pms_rise) begin
                    state_next = ST_STANDBY;
                end
            end
            ST_STANDBY: begin
                if (cal_busy) begin
                    state_next = ST_CAL;
                end else if (temp_busy) begin
                    state_next = ST_TEMP;
                end else if (radio_req) begin
                    state_next = ST_RADIO;
                end
            end
            ST_RADIO: begin
                if (!radio_mode_select) begin
                    state_next = ST_STANDBY;
                end
            end
            ST_CAL: begin
                if (!cal_busy) begin
                    state_next = ST_STANDBY;
                end
            end
            ST_TEMP: begin
                if (!temp_busy) begin
                    state_next = ST_STANDBY;
                end
            end
            default: state_next = ST_SLEEP;
        endcase
        if (!power_mode_select) begin
            state_next = ST_SLEEP;
        end
    end

    // Next values; dividers stay cleared while their state is off
    assign dir_next = mode_ctrl_wr ? mode_ctrl[DIR_BIT_POS] : dir_reg;
    assign clk_cnt_next = osc_on ? div_count(clk_cnt_reg, clk_wrap) : 4'h0;
    assign clk_out_next = osc_on && (clk_out_reg ^ clk_wrap);
    assign rx_cnt_next = receiving ? div_count(rx_cnt_reg, rx_wrap) : 4'h0;
    assign rx_clk_next = receiving && (rx_clk_reg ^ rx_wrap);
    assign sync_next = receiving && rx_sync;
    assign sdo_next = receiving && rx_data;
    assign cd_next = receiving && carrier_detect;
    assign fifo_next = osc_on && fifo_event;
    assign txd_next = transmitting && shared_data_pin_in;
    assign txen_next = transmitting && enable_detect_pin_in;

    // Reset always lands in sleep
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_reg <= ST_SLEEP;
        end else begin
            state_reg <= state_next;
        end
    end

    // Primed high so a pin held high through reset needs a fresh edge
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pms_prev_reg <= 1'b1;
        end else begin
            pms_prev_reg <= power_mode_select;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            dir_reg <= MODE_CTRL_RST[DIR_BIT_POS];
        end else begin
            dir_reg <= dir_next;
        end
    end

    // Clock output restarts in phase on every wake-up
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            clk_cnt_reg <= 4'h0;
        end else begin
            clk_cnt_reg <= clk_cnt_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            clk_out_reg <= 1'b0;
        end else begin
            clk_out_reg <= clk_out_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rx_cnt_reg <= 4'h0;
        end else begin
            rx_cnt_reg <= rx_cnt_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rx_clk_reg <= 1'b0;
        end else begin
            rx_clk_reg <= rx_clk_next;
        end
    end

    // Pin data lags the datapath by one cycle; costs latency, avoids glitches
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sync_reg <= 1'b0;
        end else begin
            sync_reg <= sync_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sdo_reg <= 1'b0;
        end else begin
            sdo_reg <= sdo_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cd_reg <= 1'b0;
        end else begin
            cd_reg <= cd_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            fifo_reg <= 1'b0;
        end else begin
            fifo_reg <= fifo_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            txd_reg <= 1'b0;
        end else begin
            txd_reg <= txd_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            txen_reg <= 1'b0;
        end else begin
            txen_reg <= txen_next;
        end
    end

    // Pins turn round with direction; drive only while receiving
    assign shared_data_pin_oe = receiving;
    assign shared_data_pin_out = sdo_reg;
    assign enable_detect_pin_oe = receiving;
    assign enable_detect_pin_out = cd_reg;
    assign tx_data = txd_reg;
    assign tx_mod_enable = txen_reg;
    assign receive_sync_pulse = sync_reg;
    assign rx_clock_pin = rx_clk_reg;
    assign fifo_status_pin = fifo_reg;
    assign clock_output_pin = clk_out_reg;
    assign osc_enable = osc_on;
    assign analog_enable = in_radio || in_cal || in_temp;
    assign tx_power = transmitting;
    assign rx_power = receiving;
    assign state_out = state_reg;

endmodule // transceiver_mode_state_control
`default_nettype wire

/* File: core/trx_state_pkg.sv */
// Constants and types for the transceiver top-level state controller
package trx_state_pkg;
    // Mode pin encodings {radio_mode_select, power_mode_select}
    localparam logic [1:0] MODE_STANDBY = 2'h1;
    localparam logic [1:0] MODE_RADIO = 2'h3;
    // Direction select bit position in the mode control word
    localparam int DIR_BIT_POS = 3;
    localparam logic DIR_RX = 1'h0;
    localparam logic DIR_TX = 1'h1;
    // Mode control word width and reset value
    localparam int MODE_CTRL_W = 16;
    localparam logic [15:0] MODE_CTRL_RST = 16'h0000;
    // Clock output divider: half period in system clocks
    localparam logic [3:0] CLK_OUT_HALF = 4'h4;
    // Receive sampling clock: half period in system clocks
    localparam logic [3:0] RX_CLK_HALF = 4'h4;
    // Top-level states
    typedef enum logic [2:0] {
        ST_SLEEP,
        ST_STANDBY,
        ST_RADIO,
        ST_CAL,
        ST_TEMP
    } top_state_e;
endpackage
